/* hdl/line_voltage_monitor_pkg.sv */
// Summary of operation
// - each phase has a private 16-bit down-counter stepping every 384 clocks
// - a zero crossing reloads that phase counter from the shared timeout register
// - shared timeout register resets to 0xffff
// - counter reaching zero before a crossing sets status bits 9 to 11
// - timeout flag with its mask bit drives the interrupt output low
// - 7-bit signed per-phase calibration delays or advances the voltage path
// - one step is 1.2 us delay or 2.4 us advance
// - period measured on phase from mode bits 1:0, 12-bit result every 4 periods
// - line-cycle mode bit 7 high shows period, low shows frequency
// - period mode: one count is 96 master clocks
// - frequency mode: one count is 0.0625 Hz
// - magnitude below sag level for programmed half cycles sets status bits 1 to 3
// - sag flag with mask bits 1 to 3 drives interrupt low
// - all phases checked in parallel against shared sag level and count
// - sag when level exceeds absolute value of sample bits 13:6
// - sag level zero disables sag detection
// - largest absolute sample bits 13:6 over fixed half cycles kept as peak
// - mode bits 4:2 choose phases for peak capture, several at once
// - peak half cycles counted from crossings on channels chosen by bits 2:0
// - monitored sample bits 13:6 above overvoltage threshold set status bit 14
// - mode bits 7:5 choose overvoltage phases; flag with mask drives interrupt
// - only a negative-to-positive transition counts as a zero crossing for timeout and period; sag and peak half cycles use either direction
// - reading the clear-on-read status copy clears the flags
package line_voltage_monitor_pkg;
    // ************************************************************
    // register offsets
    // ************************************************************
    localparam logic [7:0] ADDR_LINE_PERIOD_RESULT = 8'h10;
    localparam logic [7:0] ADDR_VOLT_PEAK = 8'h12;
    localparam logic [7:0] ADDR_MEAS_MODE = 8'h14;
    localparam logic [7:0] ADDR_LCYC = 8'h17;
    localparam logic [7:0] ADDR_MASK = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h19;
    localparam logic [7:0] ADDR_STATUS_COR = 8'h1a;
    localparam logic [7:0] ADDR_XTIMEOUT = 8'h1b;
    localparam logic [7:0] ADDR_SAG_CYCLES = 8'h1e;
    localparam logic [7:0] ADDR_SAG_LEVEL = 8'h1f;
    localparam logic [7:0] ADDR_OVLVL = 8'h20;
    localparam logic [7:0] ADDR_CAL0 = 8'h3f;
    // ************************************************************
    // field positions and reset values
    // ************************************************************
    localparam int ST_SAG_LSB = 1;
    localparam int ST_TIMEOUT_LSB = 9;
    localparam int ST_OV_BIT = 14;
    localparam int MM_PEAK_LSB = 2;
    localparam int MM_OV_LSB = 5;
    localparam int LC_PERIOD_BIT = 7;
    localparam int MAG_LSB = 6;
    localparam logic [15:0] XTIMEOUT_RST = 16'hffff;
    localparam logic [15:0] STATUS_RST = 16'h0000;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [6:0] CAL_RST = 7'h00;
    localparam logic [11:0] LINE_PERIOD_RESULT_MAX = 12'hfff;
    // ************************************************************
    // timing
    // ************************************************************
    localparam longint CLK_HZ = 40_000_000;
    localparam int CLK_PERIOD_PS = 25_000;
    localparam int TIMEOUT_TICK_CYC = 384;
    localparam int PERIOD_LSB_CYC = 96;
    localparam int PERIODS_AVG = 4;
    localparam int LINE_PERIOD_RESULT_PER_HZ = 16;
    localparam int CAL_DLY_NS = 1200;
    localparam int CAL_ADV_NS = 2400;
    localparam int CAL_BASE_NS = 151200;
    localparam int CAL_DLY_CYC = (CAL_DLY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CAL_ADV_CYC = (CAL_ADV_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CAL_BASE_CYC = (CAL_BASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [31:0] PERIOD_DIV = 32'(PERIODS_AVG * PERIOD_LSB_CYC);
    localparam logic [31:0] LINE_PERIOD_RESULT_NUM = 32'(PERIODS_AVG * LINE_PERIOD_RESULT_PER_HZ * CLK_HZ);
    localparam logic [7:0] PEAK_HALF_CYC = 8'h08;
    // ************************************************************
    // types
    // ************************************************************
    typedef logic [2:0][15:0] phase_samples_type;
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [15:0] wdata;
    } reg_req_type;
    typedef enum {DIV_IDLE, DIV_RUN} div_state_type;
endpackage

/* hdl/line_voltage_monitor.sv */
`timescale 1ns/1ps
module line_voltage_monitor
    import line_voltage_monitor_pkg::*;
#(
    parameter int CAL_BASE = CAL_BASE_CYC
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // waveform samples after the lowpass
    input wire phase_samples_type samples,
    input wire logic sample_valid,
    // register port
    input wire reg_req_type reg_req,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    // calibrated voltage path
    output phase_samples_type vcal_samples,
    output logic [2:0] vcal_valid,
    // interrupt
    output logic irq_n
);
    // ************************************************************
    // registers
    // ************************************************************
    logic [15:0] xtimeout_r;
    logic [15:0] mask_r;
    logic [15:0] status_r;
    logic [15:0] status_nxt;
    logic [7:0] meas_mode_r;
    logic [7:0] lcyc_r;
    logic [7:0] sag_lvl_r;
    logic [7:0] sag_cyc_r;
    logic [7:0] ov_lvl_r;
    logic [2:0][6:0] cal_r;
    logic [11:0] line_period_result_r;
    logic [7:0] volt_peak_r;
    logic [2:0] sag_set;
    logic [2:0] timeout_set;
    logic ov_set;
    logic clear_read;

    assign clear_read = reg_req.rd && reg_req.addr == ADDR_STATUS_COR;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            xtimeout_r <= XTIMEOUT_RST;
            mask_r <= STATUS_RST;
            meas_mode_r <= BYTE_RST;
            lcyc_r <= BYTE_RST;
            sag_lvl_r <= BYTE_RST;
            sag_cyc_r <= BYTE_RST;
            ov_lvl_r <= BYTE_RST;
            cal_r <= {3{CAL_RST}};
        end else if (reg_req.wr) begin
            case (reg_req.addr)
                ADDR_XTIMEOUT: xtimeout_r <= reg_req.wdata;
                ADDR_MASK: mask_r <= reg_req.wdata;
                ADDR_MEAS_MODE: meas_mode_r <= reg_req.wdata[7:0];
                ADDR_LCYC: lcyc_r <= reg_req.wdata[7:0];
                ADDR_SAG_LEVEL: sag_lvl_r <= reg_req.wdata[7:0];
                ADDR_SAG_CYCLES: sag_cyc_r <= reg_req.wdata[7:0];
                ADDR_OVLVL: ov_lvl_r <= reg_req.wdata[7:0];
                ADDR_CAL0: cal_r[0] <= reg_req.wdata[6:0];
                ADDR_CAL0 + 8'h01: cal_r[1] <= reg_req.wdata[6:0];
                ADDR_CAL0 + 8'h02: cal_r[2] <= reg_req.wdata[6:0];
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= 16'h0000;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= reg_req.rd;
            if (reg_req.rd) begin
                case (reg_req.addr)
                    ADDR_LINE_PERIOD_RESULT: reg_rdata <= {4'h0, line_period_result_r};
                    ADDR_VOLT_PEAK: reg_rdata <= {8'h00, volt_peak_r};
                    ADDR_MEAS_MODE: reg_rdata <= {8'h00, meas_mode_r};
                    ADDR_LCYC: reg_rdata <= {8'h00, lcyc_r};
                    ADDR_MASK: reg_rdata <= mask_r;
                    ADDR_STATUS, ADDR_STATUS_COR: reg_rdata <= status_r;
                    ADDR_XTIMEOUT: reg_rdata <= xtimeout_r;
                    ADDR_SAG_CYCLES: reg_rdata <= {8'h00, sag_cyc_r};
                    ADDR_SAG_LEVEL: reg_rdata <= {8'h00, sag_lvl_r};
                    ADDR_OVLVL: reg_rdata <= {8'h00, ov_lvl_r};
                    ADDR_CAL0: reg_rdata <= {9'h000, cal_r[0]};
                    ADDR_CAL0 + 8'h01: reg_rdata <= {9'h000, cal_r[1]};
                    ADDR_CAL0 + 8'h02: reg_rdata <= {9'h000, cal_r[2]};
                    default: reg_rdata <= 16'h0000;
                endcase
            end
        end
    end

    // ************************************************************
    // status and interrupt
    // ************************************************************
    always_comb begin
        status_nxt = clear_read ? STATUS_RST : status_r;
        // a flag raised in the clearing cycle survives the clear
        status_nxt[ST_SAG_LSB +: 3] = status_nxt[ST_SAG_LSB +: 3] | sag_set;
        status_nxt[ST_TIMEOUT_LSB +: 3] = status_nxt[ST_TIMEOUT_LSB +: 3] | timeout_set;
        status_nxt[ST_OV_BIT] = status_nxt[ST_OV_BIT] | ov_set;
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            status_r <= STATUS_RST;
        end else begin
            status_r <= status_nxt;
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq_n <= 1'b1;
        end else begin
            irq_n <= ~|(status_r & mask_r);
        end
    end

    // ************************************************************
    // per-phase crossings, timeout, sag, calibration
    // ************************************************************
    logic [2:0] pos_x;
    logic [2:0] any_x;
    logic [2:0][7:0] mag;
    logic [2:0] ov_hit;
    logic [2:0][15:0] to_cnt;
    logic [8:0] tick_div;
    logic tick;

    assign tick = tick_div == 9'(TIMEOUT_TICK_CYC - 1);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tick_div <= 9'h000;
        end else begin
            tick_div <= tick ? 9'h000 : tick_div + 9'h001;
        end
    end

    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : g_phase
            logic neg_r;
            logic [15:0] absv;
            logic below;
            logic below_half_r;
            logic [7:0] sag_cnt_r;
            logic [13:0] dly_r;
            logic [15:0] hold_r;
            int target;

            assign absv = samples[i][15] ? 16'(-samples[i]) : samples[i];
            assign mag[i] = absv[MAG_LSB +: 8];
            assign pos_x[i] = sample_valid && neg_r && !samples[i][15];
            assign any_x[i] = sample_valid && (neg_r != samples[i][15]);
            assign below = sag_lvl_r > mag[i];
            assign ov_hit[i] = meas_mode_r[MM_OV_LSB + i] && mag[i] > ov_lvl_r;
            assign timeout_set[i] = tick && to_cnt[i] == 16'h0001 && !pos_x[i];
            assign sag_set[i] = any_x[i] && sag_lvl_r != 8'h00 && below_half_r
                && sag_cnt_r + 8'h01 == sag_cyc_r;

            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    neg_r <= 1'b0;
                end else if (sample_valid) begin
                    neg_r <= samples[i][15];
                end
            end

            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    to_cnt[i] <= XTIMEOUT_RST;
                end else if (pos_x[i]) begin
                    to_cnt[i] <= xtimeout_r;
                end else if (tick && to_cnt[i] != 16'h0000) begin
                    to_cnt[i] <= to_cnt[i] - 16'h0001;
                end
            end

            // half cycles run between sign changes of the filtered waveform
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    below_half_r <= 1'b1;
                    sag_cnt_r <= 8'h00;
                end else if (any_x[i]) begin
                    // the crossing sample already belongs to the new half cycle
                    below_half_r <= below;
                    if (below_half_r && sag_lvl_r != 8'h00) begin
                        sag_cnt_r <= sag_cnt_r + 8'h01;
                    end else begin
                        sag_cnt_r <= 8'h00;
                    end
                end else if (sample_valid && !below) begin
                    below_half_r <= 1'b0;
                end
            end

            always_comb begin
                target = 0;
                if (cal_r[i][6]) begin
                    target = CAL_BASE + int'(signed'(cal_r[i])) * CAL_ADV_CYC;
                end else begin
                    target = CAL_BASE + int'(cal_r[i]) * CAL_DLY_CYC;
                end
                if (target < 1) begin
                    target = 1;
                end
            end

            // one sample in flight: a new sample restarts the delay, so the
            // delay must stay below the sample interval
            always_ff @(posedge sys_clk or negedge rstn) begin
                if (!rstn) begin
                    dly_r <= 14'h0000;
                    hold_r <= 16'h0000;
                    vcal_samples[i] <= 16'h0000;
                    vcal_valid[i] <= 1'b0;
                end else begin
                    vcal_valid[i] <= dly_r == 14'h0001;
                    if (dly_r == 14'h0001) begin
                        vcal_samples[i] <= hold_r;
                    end
                    if (sample_valid) begin
                        hold_r <= samples[i];
                        dly_r <= 14'(target);
                    end else if (dly_r != 14'h0000) begin
                        dly_r <= dly_r - 14'h0001;
                    end
                end
            end

            a_timeout_reload: assert property (@(posedge sys_clk) disable iff (!rstn)
                pos_x[i] |=> to_cnt[i] == $past(xtimeout_r))
                else $error("timeout counter not reloaded on crossing");
            a_timeout_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
                tick && to_cnt[i] == 16'h0001 && !pos_x[i] |=> status_r[ST_TIMEOUT_LSB + i]
                && to_cnt[i] == 16'h0000)
                else $error("timeout flag missing at zero");
            // watches the flag itself, not the set term that holds the level test
            a_sag_disable: assert property (@(posedge sys_clk) disable iff (!rstn)
                sag_lvl_r == 8'h00 && !status_r[ST_SAG_LSB + i] |=> !status_r[ST_SAG_LSB + i])
                else $error("sag flagged while disabled");
        end
    endgenerate

    assign ov_set = sample_valid && |ov_hit;

    // ************************************************************
    // period and frequency
    // ************************************************************
    logic [1:0] sel_ph;
    logic sel_x;
    logic armed_r;
    logic [1:0] per_cnt_r;
    logic [23:0] cyc_r;
    logic div_start;
    div_state_type div_state_r;
    logic [31:0] quo_r;
    logic [31:0] rem_r;
    logic [31:0] den_r;
    logic [4:0] bit_r;
    logic [33:0] shifted;
    logic [33:0] trial;

    assign sel_ph = meas_mode_r[1:0] == 2'h3 ? 2'h0 : meas_mode_r[1:0];
    assign sel_x = pos_x[sel_ph];
    assign div_start = sel_x && armed_r && per_cnt_r == 2'(PERIODS_AVG - 1)
        && div_state_r == DIV_IDLE && cyc_r != 24'h000000;
    assign shifted = {1'b0, rem_r, quo_r[31]};
    assign trial = shifted - {2'b00, den_r};

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            armed_r <= 1'b0;
            per_cnt_r <= 2'h0;
            cyc_r <= 24'h000000;
        end else if (sel_x) begin
            armed_r <= 1'b1;
            per_cnt_r <= armed_r ? per_cnt_r + 2'h1 : 2'h0;
            if (!armed_r || per_cnt_r == 2'(PERIODS_AVG - 1)) begin
                cyc_r <= 24'h000001;
            end else begin
                cyc_r <= cyc_r + 24'h000001;
            end
        end else if (cyc_r != 24'hffffff) begin
            cyc_r <= cyc_r + 24'h000001;
        end
    end

    // one shared 32-step divider serves both display modes
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            div_state_r <= DIV_IDLE;
            quo_r <= 32'h00000000;
            rem_r <= 32'h00000000;
            den_r <= 32'h00000001;
            bit_r <= 5'h00;
            line_period_result_r <= 12'h000;
        end else begin
            case (div_state_r)
                DIV_IDLE: begin
                    if (div_start) begin
                        if (lcyc_r[LC_PERIOD_BIT]) begin
                            quo_r <= {8'h00, cyc_r};
                            den_r <= PERIOD_DIV;
                        end else begin
                            quo_r <= LINE_PERIOD_RESULT_NUM;
                            den_r <= {8'h00, cyc_r};
                        end
                        rem_r <= 32'h00000000;
                        bit_r <= 5'h00;
                        div_state_r <= DIV_RUN;
                    end
                end
                DIV_RUN: begin
                    if (!trial[33]) begin
                        rem_r <= trial[31:0];
                        quo_r <= {quo_r[30:0], 1'b1};
                    end else begin
                        rem_r <= shifted[31:0];
                        quo_r <= {quo_r[30:0], 1'b0};
                    end
                    bit_r <= bit_r + 5'h01;
                    if (bit_r == 5'h1f) begin
                        div_state_r <= DIV_IDLE;
                        if (quo_r[30:11] != 20'h00000) begin
                            line_period_result_r <= LINE_PERIOD_RESULT_MAX;
                        end else begin
                            line_period_result_r <= {quo_r[10:0], !trial[33]};
                        end
                    end
                end
                default: div_state_r <= DIV_IDLE;
            endcase
        end
    end

    // ************************************************************
    // peak capture
    // ************************************************************
    logic [7:0] run_max_r;
    logic [7:0] hc_cnt_r;
    logic [7:0] cand;
    logic hc_x;

    assign hc_x = |(any_x & lcyc_r[2:0]);

    always_comb begin
        cand = 8'h00;
        for (int p = 0; p < 3; p++) begin
            if (meas_mode_r[MM_PEAK_LSB + p] && mag[p] > cand) begin
                cand = mag[p];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            run_max_r <= 8'h00;
            hc_cnt_r <= 8'h00;
            volt_peak_r <= 8'h00;
        end else begin
            if (hc_x && hc_cnt_r == PEAK_HALF_CYC - 8'h01) begin
                hc_cnt_r <= 8'h00;
                volt_peak_r <= run_max_r;
                run_max_r <= sample_valid ? cand : 8'h00;
            end else begin
                if (hc_x) begin
                    hc_cnt_r <= hc_cnt_r + 8'h01;
                end
                if (sample_valid && cand > run_max_r) begin
                    run_max_r <= cand;
                end
            end
        end
    end

    // ************************************************************
    // checks
    // ************************************************************
    sequence s_div_launch;
        div_start;
    endsequence
    sequence s_div_finish;
        ##33 div_state_r == DIV_IDLE;
    endsequence

    a_period_update: assert property (@(posedge sys_clk) disable iff (!rstn)
        s_div_launch |-> s_div_finish)
        else $error("period result not ready after 33 cycles");
    a_irq_low: assert property (@(posedge sys_clk) disable iff (!rstn)
        |(status_r & mask_r) |=> !irq_n)
        else $error("interrupt not asserted");
    a_irq_high: assert property (@(posedge sys_clk) disable iff (!rstn)
        (status_r & mask_r) == 16'h0000 |=> irq_n)
        else $error("interrupt stuck low");
    a_clear_read: assert property (@(posedge sys_clk) disable iff (!rstn)
        clear_read && sag_set == 3'h0 && timeout_set == 3'h0 && !ov_set
        |=> status_r == 16'h0000)
        else $error("status not cleared by read");
    a_ov_flag: assert property (@(posedge sys_clk) disable iff (!rstn)
        ov_set |=> status_r[ST_OV_BIT])
        else $error("overvoltage flag missing");
    a_peak_load: assert property (@(posedge sys_clk) disable iff (!rstn)
        hc_x && hc_cnt_r == PEAK_HALF_CYC - 8'h01 |=> volt_peak_r == $past(run_max_r))
        else $error("peak not transferred");
endmodule // line_voltage_monitor

/* verif/host_model.sv */
`timescale 1ns/1ps
module host_model
    import line_voltage_monitor_pkg::*;
(
    // register bus
    input wire logic sys_clk,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    output reg_req_type reg_req
);
    // ************
    // one access
    // ************
    initial reg_req = '0;
    // one-cycle pulse; read data is taken while rvalid stands, so a late answer shows as x
    task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d,
            output logic [15:0] q);
        @(negedge sys_clk);
        reg_req = '{wr: w, rd: !w, addr: a, wdata: d};
        @(negedge sys_clk);
        reg_req = '0;
        q = (w || reg_rvalid === 1'b1) ? reg_rdata : 'x;
    endtask
endmodule // host_model

/* verif/test_line_voltage_monitor.sv */
`timescale 1ns/1ps
module test_line_voltage_monitor
    import line_voltage_monitor_pkg::*;
;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    phase_samples_type samples = '0;
    logic sample_valid = 1'b0;
    reg_req_type reg_req;
    logic [15:0] reg_rdata;
    logic reg_rvalid;
    phase_samples_type vcal_samples;
    logic [2:0] vcal_valid;
    logic irq_n;
    int failures = 0;
    int n_checks = 0;
    logic [15:0] q;
    // long enough that an advance of one step stays above the minimum delay
    localparam int CAL_TB = 200;
    line_voltage_monitor #(.CAL_BASE(CAL_TB)) uut (.sys_clk(sys_clk), .rstn(rstn),
        .samples(samples), .sample_valid(sample_valid), .reg_req(reg_req),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .vcal_samples(vcal_samples),
        .vcal_valid(vcal_valid), .irq_n(irq_n));
    host_model host (.sys_clk(sys_clk), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .reg_req(reg_req));
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end
    // ************
    // helpers
    // ************
    task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] s);
        n_checks++;
        if (s !== e) begin
            failures++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        host.access(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        host.access(1'b0, a, 16'h0000, q);
        cmp($sformatf("reg %h", a), e, q);
    endtask
    task automatic smp(input logic [15:0] a, input logic [15:0] b, input logic [15:0] c);
        @(negedge sys_clk);
        samples = {c, b, a};
        sample_valid = 1'b1;
        @(negedge sys_clk);
        sample_valid = 1'b0;
    endtask
    // irq trails the flag by one cycle, so give it three
    task automatic irq(input logic e);
        repeat (3) @(negedge sys_clk);
        cmp("irq_n", {15'h0000, e}, {15'h0000, irq_n});
    endtask
    // positive crossings on A 1000 cycles apart; B is loud but not selected
    task automatic xings(input int n);
        repeat (n) begin
            smp(16'hfe00, 16'h2000, 16'h0040);
            smp(16'h0040, 16'h2000, 16'h0040);
            repeat (996) @(negedge sys_clk);
        end
    endtask
    // cycles from a sample on A to its delayed copy
    task automatic cal(input logic [6:0] c, input int e);
        int n;
        n = 0;
        wr(ADDR_CAL0, {9'h000, c});
        smp(16'h0123, 16'h0000, 16'h0000);
        while (vcal_valid[0] !== 1'b1 && n < 1000) begin
            @(negedge sys_clk);
            n++;
        end
        cmp("cal delay", e[15:0], n[15:0]);
        cmp("cal sample", 16'h0123, vcal_samples[0]);
    endtask
    task automatic stop_test;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        #500000;
        failures++;
        stop_test();
    end
    // ************
    // tests
    // ************
    initial begin
        repeat (8) @(negedge sys_clk);
        rstn = 1'b1;
        rd(ADDR_XTIMEOUT, XTIMEOUT_RST);
        rd(ADDR_STATUS, STATUS_RST);
        rd(8'h7f, 16'h0000);
        $display("reset test done");
        // a reload of 2 cannot expire before the second tick
        wr(ADDR_XTIMEOUT, 16'h0002);
        wr(ADDR_MASK, 16'h0e00);
        smp(16'hffc0, 16'hffc0, 16'hffc0);
        smp(16'h0040, 16'h0040, 16'h0040);
        repeat (300) @(negedge sys_clk);
        rd(ADDR_STATUS, 16'h0000);
        irq(1'b1);
        repeat (600) @(negedge sys_clk);
        irq(1'b0);
        rd(ADDR_STATUS_COR, 16'h0e00);
        rd(ADDR_STATUS, 16'h0000);
        irq(1'b1);
        wr(ADDR_XTIMEOUT, XTIMEOUT_RST);
        $display("timeout test done");
        // only phase A watched, so the large B sample must pass
        wr(ADDR_MEAS_MODE, 16'h0020);
        wr(ADDR_OVLVL, 16'h0010);
        wr(ADDR_MASK, 16'h4000);
        smp(16'h0040, 16'h1000, 16'h0040);
        rd(ADDR_STATUS, 16'h0000);
        smp(16'hf000, 16'h0040, 16'h0040);
        irq(1'b0);
        rd(ADDR_STATUS_COR, 16'h4000);
        irq(1'b1);
        $display("overvoltage test done");
        // phase C sits exactly on the level and must not count
        wr(ADDR_MEAS_MODE, 16'h0000);
        wr(ADDR_SAG_LEVEL, 16'h0010);
        wr(ADDR_SAG_CYCLES, 16'h0002);
        wr(ADDR_MASK, 16'h000e);
        for (int i = 0; i < 6; i++) begin
            q = i[0] ? 16'hffc0 : 16'h0040;
            smp(q, q, q << 4);
        end
        irq(1'b0);
        rd(ADDR_STATUS_COR, 16'h0006);
        wr(ADDR_SAG_LEVEL, 16'h0000);
        $display("sag test done");
        wr(ADDR_MEAS_MODE, 16'h0004);
        wr(ADDR_LCYC, 16'h0081);
        xings(5);
        rd(ADDR_LINE_PERIOD_RESULT, 16'(PERIODS_AVG * 1000 / (PERIODS_AVG * PERIOD_LSB_CYC)));
        rd(ADDR_VOLT_PEAK, 16'h0008);
        $display("period and peak test done");
        // a 1000-cycle period is far too short for the 12-bit frequency range
        wr(ADDR_LCYC, 16'h0001);
        xings(4);
        rd(ADDR_LINE_PERIOD_RESULT, {4'h0, LINE_PERIOD_RESULT_MAX});
        $display("frequency test done");
        cal(7'h00, CAL_TB);
        cal(7'h02, CAL_TB + 2 * CAL_DLY_CYC);
        cal(7'h7f, CAL_TB - CAL_ADV_CYC);
        $display("calibration test done");
        stop_test();
    end
endmodule // test_line_voltage_monitor
